// file: logic/hsps_port_select.sv
// Serial port selection, SPI slave and UART-side flow control
`timescale 1ns/100ps
module hsps_port_select
  import hsps_pkg::*;
#(
  parameter int CHAR_CYC = CHAR_CYC_DEF
)(
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        uart_cfg_pin,
  input  wire logic        uart_tx_force_spi,
  input  wire logic        spi_sck,
  input  wire logic        slave_select_low,
  input  wire logic        spi_mosi,
  input  wire logic        rts_n,
  output logic             spi_miso,
  output logic             spi_miso_oe,
  output logic             host_attention_n,
  output logic             host_attention_oe,
  output logic             data_pending_indicator,
  output logic             cts_n,
  input  wire logic        uart_in_pin_periph,
  input  wire logic        uart_out_pin_periph,
  input  wire logic [2:0]  attention_pin_function,
  input  wire logic [2:0]  clock_pin_function,
  input  wire logic [2:0]  select_pin_function,
  input  wire logic [2:0]  slave_in_pin_function,
  input  wire logic [2:0]  slave_out_pin_function,
  input  wire logic [2:0]  request_to_send_setting,
  input  wire logic [2:0]  clear_to_send_setting,
  input  wire logic [1:0]  frame_escape_setting,
  input  wire logic [7:0]  packetization_timeout,
  input  wire logic [7:0]  max_packet_chars,
  input  wire logic        cmd_seq_seen,
  output logic [2:0]       eff_attention_fn,
  output logic [2:0]       eff_clock_fn,
  output logic [2:0]       eff_select_fn,
  output logic [2:0]       eff_slave_in_fn,
  output logic [2:0]       eff_slave_out_fn,
  output logic [2:0]       active_sel,
  output logic             uart_default_cfg,
  output logic             command_mode,
  output logic             escaped_framing,
  output logic             modem_status_req,
  input  wire logic        uart_rx_valid,
  input  wire logic [7:0]  uart_rx_data,
  input  wire logic        uart_core_ready,
  output logic             uart_out_strobe,
  output logic [7:0]       uart_out_data,
  output logic             rxq_push,
  output logic [7:0]       rxq_data,
  input  wire logic        rxq_pop,
  output logic             rx_drop,
  output logic             packetize,
  input  wire logic        tx_in_valid,
  output logic             tx_in_ready,
  input  wire logic [7:0]  tx_in_data,
  input  wire logic        rf_pkt_offer,
  input  wire logic [7:0]  rf_pkt_len,
  input  wire logic [9:0]  tx_space_free,
  output logic             rf_pkt_accept,
  output logic             rf_pkt_drop
);
  typedef struct packed {
    hsps_sel_type sel;
    logic [2:0]   boot_cnt;
    logic         cfg_def;
    logic         cmd_mode;
    logic         forced;
    logic         status_pend;
    logic         sck_q;
    logic         ss_q;
    logic [7:0]   shin;
    logic [2:0]   bitcnt;
    logic [7:0]   shout;
    logic         shout_valid;
    logic         miso;
    logic         miso_oe;
    logic         attn_n;
    logic         attn_oe;
    logic         dpi_n;
    logic         cts_n;
    logic [9:0]   level;
    logic         push;
    logic [7:0]   rx_data;
    logic         drop;
    logic [7:0]   chars;
    logic [23:0]  idle;
    logic         pktz;
    logic         acc;
    logic         rej;
    logic         ustrobe;
    logic [7:0]   udata;
    logic         msreq;
    logic [14:0]  eff;
  } hsps_top_type;

  hsps_top_type      r;
  hsps_top_type      n;
  logic [PIN_W-1:0]  pin_q;
  logic              spi_in_valid;
  logic              spi_in_ready;
  logic              spi_buf_valid;
  logic [7:0]        spi_buf_data;
  logic              spi_pop;
  logic              uart_in_valid;
  logic              uart_in_ready;
  logic              uart_buf_valid;
  logic [7:0]        uart_buf_data;
  logic              uart_pop;
  logic              uart_en;
  logic              spi_en;
  logic              spi_live;
  logic              uart_live;
  logic              ss_act;
  logic              rx_ev;
  logic              rx_spi;
  logic [7:0]        rx_byte;
  logic [9:0]        free;
  logic              transp;
  logic [23:0]       idle_lim;

  hsps_sync u_sync (
    .clk_sys (clk_sys),
    .arst_n  (arst_n),
    .pins    ({rts_n, spi_mosi, slave_select_low, spi_sck, uart_tx_force_spi, uart_cfg_pin}),
    .pins_q  (pin_q)
  );

  hsps_buf2 u_spi_buf (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .in_valid  (spi_in_valid),
    .in_ready  (spi_in_ready),
    .in_data   (tx_in_data),
    .out_valid (spi_buf_valid),
    .out_ready (spi_pop),
    .out_data  (spi_buf_data)
  );

  hsps_buf2 u_uart_buf (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .in_valid  (uart_in_valid),
    .in_ready  (uart_in_ready),
    .in_data   (tx_in_data),
    .out_valid (uart_buf_valid),
    .out_ready (uart_pop),
    .out_data  (uart_buf_data)
  );

  // ----------------------------------------------------------------
  // Port enables and routing
  // ----------------------------------------------------------------
  assign uart_en   = uart_in_pin_periph && uart_out_pin_periph;
  assign spi_en    = (slave_out_pin_function == PF_PERIPH) && (slave_in_pin_function == PF_PERIPH)
                  && (select_pin_function == PF_PERIPH) && (clock_pin_function == PF_PERIPH);
  assign spi_live  = (r.sel == SEL_SPI) || (r.sel == SEL_BOTH);
  assign uart_live = (r.sel == SEL_UART) || (r.sel == SEL_BOTH);
  assign ss_act    = !pin_q[PIN_SS] && spi_live;
  // Tx stream goes to the UART once UART or both ports are chosen, until SPI is chosen
  assign spi_in_valid  = tx_in_valid && (r.sel == SEL_SPI);
  assign uart_in_valid = tx_in_valid && uart_live;
  assign tx_in_ready   = (r.sel == SEL_SPI) ? spi_in_ready : (uart_live && uart_in_ready);
  assign free          = RX_DEPTH - r.level;
  assign transp        = (r.sel == SEL_UART) && (frame_escape_setting == FRAME_TRANSP) && !r.cmd_mode;
  assign idle_lim      = 24'(packetization_timeout * CHAR_CYC);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n         = r;
    spi_pop   = 1'b0;
    uart_pop  = 1'b0;
    rx_ev     = 1'b0;
    rx_spi    = 1'b0;
    rx_byte   = uart_rx_data;
    n.push    = 1'b0;
    n.drop    = 1'b0;
    n.pktz    = 1'b0;
    n.acc     = 1'b0;
    n.rej     = 1'b0;
    n.ustrobe = 1'b0;
    n.msreq   = 1'b0;
    n.sck_q   = pin_q[PIN_SCK];
    n.ss_q    = pin_q[PIN_SS];
    // SPI slave, mode 0: sample on rise, shift on fall, MSB first
    if (!ss_act) begin
      n.bitcnt = 3'h0;
    end else if (r.ss_q) begin
      n.bitcnt      = 3'h0;
      n.status_pend = 1'b0;
      n.shout_valid = spi_buf_valid;
      spi_pop       = spi_buf_valid;
      if (spi_buf_valid) begin
        n.shout = spi_buf_data;
        n.miso  = spi_buf_data[7];
      end
    end else if (!r.sck_q && pin_q[PIN_SCK]) begin
      n.shin   = {r.shin[6:0], pin_q[PIN_MOSI]};
      n.bitcnt = r.bitcnt + 3'h1;
      if (r.bitcnt == 3'h7) begin
        rx_ev   = 1'b1;
        rx_spi  = 1'b1;
        rx_byte = {r.shin[6:0], pin_q[PIN_MOSI]};
      end
    end else if (r.sck_q && !pin_q[PIN_SCK]) begin
      if (r.bitcnt == 3'h0) begin
        n.shout_valid = spi_buf_valid;
        spi_pop       = spi_buf_valid;
        if (spi_buf_valid) begin
          n.shout = spi_buf_data;
          n.miso  = spi_buf_data[7];
        end
      end else if (r.shout_valid) begin
        n.shout = {r.shout[6:0], 1'b0};
        n.miso  = r.shout[6];
      end
      // Empty buffer: miso simply holds its last value
    end
    n.miso_oe = ss_act;
    if (uart_live && uart_rx_valid && !rx_ev) begin
      rx_ev = 1'b1;
    end
    // Port selection
    case (r.sel)
      SEL_BOOT: begin
        if (r.boot_cnt == BOOT_CNT_MAX) begin
          if (!pin_q[PIN_CFG]) begin
            n.cfg_def  = 1'b1;
            n.cmd_mode = 1'b1;
            n.sel      = SEL_UART;
          end else if (!pin_q[PIN_FORCE]) begin
            n.sel = SEL_FORCE;
          end else if (uart_en && spi_en) begin
            n.sel = SEL_BOTH;
          end else if (spi_en) begin
            n.sel = SEL_SPI;
          end else begin
            n.sel = SEL_UART;
          end
        end else begin
          n.boot_cnt = r.boot_cnt + 3'h1;
        end
      end
      SEL_FORCE: begin
        n.forced      = 1'b1;
        n.status_pend = 1'b1;
        n.msreq       = 1'b1;
        n.sel         = SEL_SPI;
      end
      SEL_BOTH: begin
        if (!pin_q[PIN_SS] || rx_spi) begin
          n.sel = SEL_SPI;
        end else if (uart_rx_valid) begin
          n.sel = SEL_UART;
        end
      end
      default: begin
      end
    endcase
    // Forced pin functions live in flops, so any reset reverts them
    n.eff = {attention_pin_function, clock_pin_function, select_pin_function,
             slave_in_pin_function, slave_out_pin_function};
    if (n.forced) begin
      n.eff = {(attention_pin_function == 3'h0) ? ATTN_FN_SPI : attention_pin_function,
               PF_PERIPH, PF_PERIPH, PF_PERIPH, PF_PERIPH};
    end
    // Receive buffer accounting
    if (rx_ev && (r.level == RX_DEPTH)) begin
      n.drop = 1'b1;
    end else if (rx_ev) begin
      n.push    = 1'b1;
      n.rx_data = rx_byte;
    end
    n.level = r.level + {9'h000, n.push} - {9'h000, rxq_pop && (r.level != 10'h000)};
    if (clear_to_send_setting != FLOW_FN_ON) begin
      n.cts_n = 1'b0;
    end else if (free <= CTS_OFF_FREE) begin
      n.cts_n = 1'b1;
    end else if (free >= CTS_ON_FREE) begin
      n.cts_n = 1'b0;
    end
    // Transparent packetization
    if (transp) begin
      if (n.push) begin
        n.chars = r.chars + 8'h01;
        n.idle  = 24'h000000;
      end else if (r.chars != 8'h00) begin
        n.idle = r.idle + 24'h000001;
      end
      if ((n.push && (packetization_timeout == 8'h00)) || cmd_seq_seen
          || (n.chars == max_packet_chars)
          || ((r.chars != 8'h00) && !n.push && (n.idle >= idle_lim))) begin
        n.pktz  = 1'b1;
        n.chars = 8'h00;
        n.idle  = 24'h000000;
      end
    end
    // Whole radio packets only
    if (rf_pkt_offer) begin
      n.acc = ({2'b00, rf_pkt_len} <= tx_space_free);
      n.rej = ({2'b00, rf_pkt_len} > tx_space_free);
    end
    // UART output, paused while request-to-send is negated
    if (uart_buf_valid && uart_core_ready && !r.ustrobe
        && !((request_to_send_setting == FLOW_FN_ON) && pin_q[PIN_RTS])) begin
      uart_pop  = 1'b1;
      n.ustrobe = 1'b1;
      n.udata   = uart_buf_data;
    end
    n.dpi_n   = !((attention_pin_function == DPI_FN_ON) && uart_buf_valid);
    n.attn_oe = (r.eff[14:12] == ATTN_FN_SPI) && (r.sel == SEL_SPI);
    n.attn_n  = !((r.sel == SEL_SPI) && (spi_buf_valid || r.status_pend));
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      r        <= '0;
      r.sel    <= SEL_BOOT;
      r.ss_q   <= 1'b1;
      r.attn_n <= 1'b1;
      r.dpi_n  <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign spi_miso               = r.miso;
  assign spi_miso_oe            = r.miso_oe;
  assign host_attention_n       = r.attn_n;
  assign host_attention_oe      = r.attn_oe;
  assign data_pending_indicator = r.dpi_n;
  assign cts_n                  = r.cts_n;
  assign {eff_attention_fn, eff_clock_fn, eff_select_fn, eff_slave_in_fn, eff_slave_out_fn} = r.eff;
  assign active_sel             = r.sel;
  assign uart_default_cfg       = r.cfg_def;
  assign command_mode           = r.cmd_mode;
  // SPI is never escaped, whatever the setting says
  assign escaped_framing        = (r.sel == SEL_UART) && (frame_escape_setting == 2'h2);
  assign modem_status_req       = r.msreq;
  assign uart_out_strobe        = r.ustrobe;
  assign uart_out_data          = r.udata;
  assign rxq_push               = r.push;
  assign rxq_data               = r.rx_data;
  assign rx_drop                = r.drop;
  assign packetize              = r.pktz;
  assign rf_pkt_accept          = r.acc;
  assign rf_pkt_drop            = r.rej;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  sequence force_seen_s;
    r.sel == SEL_FORCE;
  endsequence
  sequence status_out_s;
    (r.msreq && r.sel == SEL_SPI) ##1 !r.attn_n;
  endsequence

  miso_tristate_a: assert property (!ss_act |=> !spi_miso_oe) else $error("miso driven unselected");
  uart_only_a: assert property (r.sel == SEL_UART |=> !spi_miso_oe) else $error("spi used in uart");
  forced_status_a: assert property (force_seen_s |=> status_out_s) else $error("no status");
  both_select_a: assert property (r.sel == SEL_BOTH && !pin_q[PIN_SS] |=> r.sel == SEL_SPI)
    else $error("select ignored");
  first_input_a: assert property (r.sel == SEL_BOTH && pin_q[PIN_SS] && uart_rx_valid && !rx_spi
    |=> r.sel == SEL_UART [*2]) else $error("uart not latched");
  none_fallback_a: assert property (r.sel == SEL_BOOT && r.boot_cnt == BOOT_CNT_MAX && pin_q[PIN_CFG]
    && pin_q[PIN_FORCE] && !uart_en && !spi_en |=> r.sel == SEL_UART) else $error("no uart");
  rx_overflow_a: assert property (rx_ev && r.level == RX_DEPTH |=> rx_drop && !rxq_push)
    else $error("overflow kept");
  cts_negate_a: assert property (clear_to_send_setting == FLOW_FN_ON && free <= CTS_OFF_FREE
    |=> cts_n) else $error("cts stays low");
  pkt_whole_a: assert property (rf_pkt_offer && {2'b00, rf_pkt_len} > tx_space_free
    |=> rf_pkt_drop && !rf_pkt_accept) else $error("partial packet");
  last_bit_a: assert property (ss_act && !r.ss_q && r.sck_q && !pin_q[PIN_SCK]
    && r.bitcnt == 3'h0 && !spi_buf_valid |=> $stable(spi_miso)) else $error("idle bit moved");
  dpi_low_a: assert property (attention_pin_function == DPI_FN_ON && uart_buf_valid
    |=> !data_pending_indicator) else $error("indicator high");
endmodule

// file: logic/hsps_pkg.sv
// Constants and types for the host serial port selection block
package hsps_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS   = 40;
  localparam int          CHAR_TIME_US    = 1042;
  localparam int          CHAR_CYC_DEF    = (CHAR_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int          UART_DEF_BAUD   = 9600;
  // Straps are judged only once the pin filter has settled after reset
  localparam logic [2:0]  BOOT_CNT_MAX    = 3'h4;
  // ----------------------------------------------------------------
  // Pin function codes
  // ----------------------------------------------------------------
  localparam logic [2:0]  PF_PERIPH       = 3'h1;
  localparam logic [2:0]  ATTN_FN_SPI     = 3'h1;
  localparam logic [2:0]  DPI_FN_ON       = 3'h6;
  localparam logic [2:0]  FLOW_FN_ON      = 3'h1;
  localparam logic [1:0]  FRAME_TRANSP    = 2'h0;
  // ----------------------------------------------------------------
  // Receive buffer
  // ----------------------------------------------------------------
  localparam logic [9:0]  RX_DEPTH        = 10'h100;
  localparam logic [9:0]  CTS_OFF_FREE    = 10'h011;
  localparam logic [9:0]  CTS_ON_FREE     = 10'h022;
  // ----------------------------------------------------------------
  // Pin sampler bit positions
  // ----------------------------------------------------------------
  localparam int          PIN_CFG         = 0;
  localparam int          PIN_FORCE       = 1;
  localparam int          PIN_SCK         = 2;
  localparam int          PIN_SS          = 3;
  localparam int          PIN_MOSI        = 4;
  localparam int          PIN_RTS         = 5;
  localparam int          PIN_W           = 6;
  localparam logic [5:0]  PIN_RST         = 6'h3F;

  typedef enum logic [2:0] {SEL_BOOT, SEL_FORCE, SEL_BOTH, SEL_UART, SEL_SPI} hsps_sel_type;
endpackage

// file: logic/hsps_sync.sv
// Three-stage pin sampler with agreement filter
`timescale 1ns/100ps
module hsps_sync
  import hsps_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             arst_n,
  input  wire logic [PIN_W-1:0] pins,
  output logic      [PIN_W-1:0] pins_q
);
  typedef struct packed {
    logic [PIN_W-1:0] s1;
    logic [PIN_W-1:0] s2;
    logic [PIN_W-1:0] s3;
    logic [PIN_W-1:0] q;
  } hsps_sync_type;

  hsps_sync_type r;
  hsps_sync_type n;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n    = r;
    n.s1 = pins;
    n.s2 = r.s1;
    n.s3 = r.s2;
    // A bit moves only once stages two and three agree
    n.q  = (~(r.s2 ^ r.s3) & r.s2) | ((r.s2 ^ r.s3) & r.q);
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      r <= {4{PIN_RST}};
    end else begin
      r <= n;
    end
  end

  assign pins_q = r.q;
endmodule

// file: logic/hsps_buf2.sv
// Two-entry byte buffer with valid/ready on both sides
`timescale 1ns/100ps
module hsps_buf2
  import hsps_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  input  wire logic       in_valid,
  output logic            in_ready,
  input  wire logic [7:0] in_data,
  output logic            out_valid,
  input  wire logic       out_ready,
  output logic      [7:0] out_data
);
  typedef struct packed {
    logic [1:0][7:0] mem;
    logic [1:0]      cnt;
  } hsps_buf2_type;

  hsps_buf2_type r;
  hsps_buf2_type n;
  logic          push;
  logic          pop;

  // ----------------------------------------------------------------
  // Entry 0 is always the head
  // ----------------------------------------------------------------
  always_comb begin
    n    = r;
    push = in_valid && (r.cnt != 2'h2);
    pop  = out_ready && (r.cnt != 2'h0);
    if (pop) begin
      n.mem[0] = r.mem[1];
    end
    if (push) begin
      n.mem[(pop ? r.cnt - 2'h1 : r.cnt) == 2'h0 ? 0 : 1] = in_data;
    end
    n.cnt = r.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign in_ready  = (r.cnt != 2'h2);
  assign out_valid = (r.cnt != 2'h0);
  assign out_data  = r.mem[0];
endmodule

// file: verif/hsps_spi_host.sv
// SPI master model standing in for the host processor
`timescale 1ns/100ps
module hsps_spi_host (
  output logic      sck,
  output logic      ss_n,
  output logic      mosi,
  input  wire logic miso
);
  logic [7:0] got;
  // ---------------------------------------------------------------
  // Idle levels
  // ---------------------------------------------------------------
  initial begin
    sck = 1'h0;
    ss_n = 1'h1;
    mosi = 1'h1;
  end
  // ---------------------------------------------------------------
  // One byte per frame, so the receive buffer never floods
  // ---------------------------------------------------------------
  task automatic xfer(input logic [7:0] tx);
    ss_n = 1'h0;
    #200;
    for (int i = 7; i >= 0; i--) begin
      mosi = tx[i];
      #160 sck = 1'h1;
      got[i] = miso;
      #160 sck = 1'h0;
    end
    #200 ss_n = 1'h1;
    mosi = 1'h1; // Pull-up takes the released line
  endtask
endmodule

// file: verif/hsps_port_select_tb.sv
// Self-checking bench for the host serial port selection block
`timescale 1ns/100ps
module hsps_port_select_tb;
  import hsps_pkg::*;
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fails++; \
  $display("unexpected at %0t: got %0h want %0h", $time, a, b); end end
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic       clk_sys = 1'h0, arst_n = 1'h0, uart_cfg_pin = 1'h1, uart_tx_force_spi = 1'h1,
              rts_n = 1'h0, uart_in_pin_periph = 1'h1, uart_out_pin_periph = 1'h1,
              cmd_seq_seen = 1'h0, uart_rx_valid = 1'h0, uart_core_ready = 1'h1,
              rxq_pop = 1'h0, tx_in_valid = 1'h0, rf_pkt_offer = 1'h0;
  logic [2:0] attention_pin_function = 3'h0, clock_pin_function = 3'h0,
              select_pin_function = 3'h0, slave_in_pin_function = 3'h0,
              slave_out_pin_function = 3'h0, request_to_send_setting = 3'h0,
              clear_to_send_setting = 3'h0, eff_attention_fn, eff_clock_fn, active_sel;
  logic [1:0] frame_escape_setting = 2'h0;
  logic [7:0] packetization_timeout = 8'h0, max_packet_chars = 8'h10, uart_rx_data = 8'h0,
              tx_in_data = 8'h0, rf_pkt_len = 8'h0, uart_out_data, rxq_data, last_rx, first_out;
  logic [9:0] tx_space_free = 10'h0;
  logic       spi_sck, slave_select_low, spi_mosi, spi_miso, spi_miso_oe, host_attention_n,
              host_attention_oe, cts_n, uart_default_cfg, command_mode, escaped_framing,
              uart_out_strobe, rxq_push, rx_drop, tx_in_ready, rf_pkt_accept, rf_pkt_drop,
              oe_seen;
  int         fails = 0, n_checks = 0, n_push, n_drop, n_out;

  always #20 clk_sys = ~clk_sys;

  hsps_port_select #(.CHAR_CYC(4)) hsps_port_select_inst (
    .clk_sys, .arst_n, .uart_cfg_pin, .uart_tx_force_spi, .spi_sck, .slave_select_low,
    .spi_mosi, .rts_n, .spi_miso, .spi_miso_oe, .host_attention_n, .host_attention_oe,
    .data_pending_indicator(), .cts_n, .uart_in_pin_periph, .uart_out_pin_periph,
    .attention_pin_function, .clock_pin_function, .select_pin_function,
    .slave_in_pin_function, .slave_out_pin_function, .request_to_send_setting,
    .clear_to_send_setting, .frame_escape_setting, .packetization_timeout,
    .max_packet_chars, .cmd_seq_seen, .eff_attention_fn, .eff_clock_fn, .eff_select_fn(),
    .eff_slave_in_fn(), .eff_slave_out_fn(), .active_sel, .uart_default_cfg, .command_mode,
    .escaped_framing, .modem_status_req(), .uart_rx_valid, .uart_rx_data, .uart_core_ready,
    .uart_out_strobe, .uart_out_data, .rxq_push, .rxq_data, .rxq_pop, .rx_drop,
    .packetize(), .tx_in_valid, .tx_in_ready, .tx_in_data, .rf_pkt_offer, .rf_pkt_len,
    .tx_space_free, .rf_pkt_accept, .rf_pkt_drop);

  hsps_spi_host hsps_spi_host_inst (.sck(spi_sck), .ss_n(slave_select_low), .mosi(spi_mosi),
    .miso(spi_miso));
  // ---------------------------------------------------------------
  // Monitor; counts restart with every reset
  // ---------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!arst_n) begin
      n_push = 0; n_drop = 0; n_out = 0; oe_seen = 1'h0;
    end
    if (rxq_push === 1'h1) begin
      n_push++; last_rx = rxq_data;
    end
    if (uart_out_strobe === 1'h1) begin
      n_out++; if (n_out == 1) first_out = uart_out_data;
    end
    if (rx_drop === 1'h1) n_drop++;
    if (spi_miso_oe === 1'h1) oe_seen = 1'h1;
  end
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic boot(input logic c, f, u, s);
    arst_n <= 1'h0;
    uart_cfg_pin <= c;
    uart_tx_force_spi <= f;
    uart_in_pin_periph <= u;
    uart_out_pin_periph <= u;
    request_to_send_setting <= u ? FLOW_FN_ON : 3'h0;
    clear_to_send_setting <= u ? FLOW_FN_ON : 3'h0;
    clock_pin_function <= s ? PF_PERIPH : 3'h0;
    select_pin_function <= s ? PF_PERIPH : 3'h0;
    slave_in_pin_function <= s ? PF_PERIPH : 3'h0;
    slave_out_pin_function <= s ? PF_PERIPH : 3'h0;
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'h1;
    repeat (8) @(posedge clk_sys);
  endtask
  task automatic uart_in(input logic [7:0] d);
    @(posedge clk_sys);
    uart_rx_valid <= 1'h1;
    uart_rx_data <= d;
    @(posedge clk_sys);
    uart_rx_valid <= 1'h0;
    repeat (3) @(posedge clk_sys);
  endtask
  task automatic rf_offer(input logic [7:0] n, input logic [9:0] room);
    @(posedge clk_sys);
    rf_pkt_offer <= 1'h1;
    rf_pkt_len <= n;
    tx_space_free <= room;
    @(posedge clk_sys);
    rf_pkt_offer <= 1'h0;
    #1;
  endtask
  task automatic summarize;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_uart;
    boot(1'h1, 1'h1, 1'h1, 1'h0);
    frame_escape_setting <= 2'h2;
    `CHK(active_sel, SEL_UART)
    hsps_spi_host_inst.xfer(8'h5A);
    uart_in(8'hC3);
    `CHK(n_push, 1)
    `CHK(last_rx, 8'hC3)
    `CHK(oe_seen, 1'h0)
    `CHK(escaped_framing, 1'h1)
    rf_offer(8'h0A, 10'h009);
    `CHK(rf_pkt_drop, 1'h1)
    rf_offer(8'h09, 10'h009);
    `CHK(rf_pkt_accept, 1'h1)
    $display("uart only test done");
  endtask
  task automatic t_both;
    boot(1'h1, 1'h1, 1'h1, 1'h1);
    `CHK(active_sel, SEL_BOTH)
    hsps_spi_host_inst.xfer(8'hA5);
    repeat (7) @(posedge clk_sys);
    `CHK(last_rx, 8'hA5)
    `CHK(active_sel, SEL_SPI)
    `CHK(oe_seen, 1'h1)
    `CHK(spi_miso_oe, 1'h0)
    uart_in(8'h42);
    `CHK(n_push, 1)
    `CHK(escaped_framing, 1'h0)
    boot(1'h1, 1'h1, 1'h1, 1'h1);
    uart_in(8'h11);
    `CHK(active_sel, SEL_UART)
    hsps_spi_host_inst.xfer(8'h22);
    repeat (7) @(posedge clk_sys);
    `CHK(n_push, 1)
    `CHK(oe_seen, 1'h0)
    $display("both ports test done");
  endtask
  task automatic t_buf;
    boot(1'h1, 1'h1, 1'h1, 1'h0);
    uart_rx_valid <= 1'h1;
    repeat (257) @(posedge clk_sys);
    uart_rx_valid <= 1'h0;
    repeat (2) @(posedge clk_sys);
    `CHK(n_push, 256)
    `CHK(n_drop, 1)
    `CHK(cts_n, 1'h1)
    rxq_pop <= 1'h1;
    repeat (33) @(posedge clk_sys);
    rxq_pop <= 1'h0;
    repeat (2) @(posedge clk_sys);
    `CHK(cts_n, 1'h1)
    rxq_pop <= 1'h1;
    @(posedge clk_sys);
    rxq_pop <= 1'h0;
    repeat (2) @(posedge clk_sys);
    `CHK(cts_n, 1'h0)
    $display("receive buffer test done");
  endtask
  task automatic t_flow;
    boot(1'h1, 1'h1, 1'h1, 1'h0);
    rts_n <= 1'h1;
    repeat (6) @(posedge clk_sys);
    for (int i = 0; i < 2; i++) begin
      tx_in_valid <= 1'h1;
      tx_in_data <= 8'h30 + 8'(i);
      @(posedge clk_sys iff tx_in_ready === 1'h1);
    end
    tx_in_valid <= 1'h0;
    repeat (10) @(posedge clk_sys);
    `CHK(n_out, 0)
    rts_n <= 1'h0;
    repeat (12) @(posedge clk_sys);
    `CHK(n_out, 2)
    `CHK(first_out, 8'h30)
    $display("flow control test done");
  endtask
  task automatic t_strap;
    boot(1'h0, 1'h1, 1'h0, 1'h0);
    `CHK(active_sel, SEL_UART)
    `CHK(uart_default_cfg, 1'h1)
    `CHK(command_mode, 1'h1)
    $display("strap test done");
  endtask
  task automatic t_force;
    boot(1'h1, 1'h0, 1'h1, 1'h0);
    for (int i = 0; i < 200 && host_attention_n !== 1'h0; i++) @(posedge clk_sys);
    uart_tx_force_spi <= 1'h1;
    `CHK(host_attention_n, 1'h0)
    `CHK(host_attention_oe, 1'h1)
    `CHK(eff_clock_fn, PF_PERIPH)
    `CHK(eff_attention_fn, ATTN_FN_SPI)
    uart_in(8'h77);
    `CHK(n_push, 0)
    hsps_spi_host_inst.xfer(8'h3C);
    repeat (4) @(posedge clk_sys);
    `CHK(last_rx, 8'h3C)
    $display("forced spi test done");
  endtask
  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    t_uart;
    t_both;
    t_buf;
    t_flow;
    t_strap;
    t_force;
    summarize;
  end
  initial begin
    #300_000;
    fails++;
    summarize;
  end
endmodule
